/* src/tbd_params.svh */
// Field positions, register offsets and reset values for the transmit command decoder
`ifndef TBD_PARAMS_SVH
`define TBD_PARAMS_SVH

// First command word fields
`define TBD_A_IOC 31
`define TBD_A_ALIGN_HI 25
`define TBD_A_ALIGN_LO 24
`define TBD_A_OFF_HI 20
`define TBD_A_OFF_LO 16
`define TBD_A_FIRST 13
`define TBD_A_LAST 12
`define TBD_A_SIZE_HI 10
`define TBD_A_SIZE_LO 0

// Second command word packet length field
`define TBD_B_LEN_HI 10
`define TBD_B_LEN_LO 0

// End alignment codes
`define TBD_ALIGN_4 2'h0
`define TBD_ALIGN_16 2'h1
`define TBD_ALIGN_32 2'h2
`define TBD_ALIGN_RSVD 2'h3

// Register offsets
`define TBD_OFF_INTERRUPT_STATUS_REGISTER 8'h00
`define TBD_OFF_INT_MASK 8'h04
`define TBD_OFF_PKT_STAT 8'h08

// Interrupt status bit positions
`define TBD_STS_CMPL 0
`define TBD_STS_ERR 1
`define TBD_STS_W 2

// Reset values
`define TBD_STS_RST 2'h0
`define TBD_MASK_RST 2'h0

`endif

/* src/tbd_pkg.sv */
// Types shared by the transmit command decoder modules
package tbd_pkg;

   typedef enum logic [1:0] {
      TBD_ST_CMD_A,
      TBD_ST_CMD_B,
      TBD_ST_DATA
   } tbd_state_t;

   typedef struct packed {
      logic completion_interrupt_request;
      logic [1:0] align;
      logic [4:0] offset;
      logic first;
      logic last;
      logic [10:0] size;
   } tbd_cmd_a_t;

endpackage : tbd_pkg

/* src/tbd_cmd_if.sv */
// Interface between the sequencer and the first command word decoder
`timescale 1ns/1ps
interface tbd_cmd_if;
   logic [31:0] word;
   tbd_pkg::tbd_cmd_a_t cmd;
   logic [9:0] data_dw;
   logic [9:0] total_dw;
   logic bad_align;

   modport dec (
      input word,
      output cmd,
      output data_dw,
      output total_dw,
      output bad_align
   );

   modport user (
      output word,
      input cmd,
      input data_dw,
      input total_dw,
      input bad_align
   );
endinterface : tbd_cmd_if

/* src/tbd_cmd_decode.sv */
// Combinational decode of the first command word into fields and DWORD counts
`timescale 1ns/1ps
`include "tbd_params.svh"
module tbd_cmd_decode (
   tbd_cmd_if.dec cif
);
   import tbd_pkg::*;

   logic [11:0] span;
   logic [9:0] dw;

   always_comb begin
      // Reserved bits are not looked at, host keeps them zero
      cif.cmd.completion_interrupt_request = cif.word[`TBD_A_IOC];
      cif.cmd.align = cif.word[`TBD_A_ALIGN_HI:`TBD_A_ALIGN_LO];
      cif.cmd.offset = cif.word[`TBD_A_OFF_HI:`TBD_A_OFF_LO];
      cif.cmd.first = cif.word[`TBD_A_FIRST];
      cif.cmd.last = cif.word[`TBD_A_LAST];
      cif.cmd.size = cif.word[`TBD_A_SIZE_HI:`TBD_A_SIZE_LO];
   end

   // Offset and size together cover every DWORD holding payload
   assign span = 12'(cif.cmd.offset) + 12'(cif.cmd.size) + 12'h003;
   assign dw = span[11:2];
   assign cif.data_dw = dw;
   assign cif.bad_align = (cif.cmd.align == `TBD_ALIGN_RSVD);

   // Round up to the alignment; reserved code falls back to 4-byte
   always_comb begin
      case (cif.cmd.align)
         `TBD_ALIGN_16: cif.total_dw = (dw + 10'h003) & 10'h3FC;
         `TBD_ALIGN_32: cif.total_dw = (dw + 10'h007) & 10'h3F8;
         default: cif.total_dw = dw;
      endcase
   end
endmodule : tbd_cmd_decode

/* src/tbd_int_regs.sv */
// Sticky interrupt status with write-one-to-clear and mask gating
`timescale 1ns/1ps
`include "tbd_params.svh"
module tbd_int_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`TBD_STS_W-1:0] set_evt,
   input wire logic [`TBD_STS_W-1:0] clr_w1c,
   input wire logic mask_we,
   input wire logic [`TBD_STS_W-1:0] mask_wdata,
   output logic [`TBD_STS_W-1:0] sts_r,
   output logic [`TBD_STS_W-1:0] mask_r,
   output logic irq_r
);
   import tbd_pkg::*;

   // Set wins over a clear landing in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sts_r <= `TBD_STS_RST;
      end else begin
         sts_r <= (sts_r & ~clr_w1c) | set_evt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_r <= `TBD_MASK_RST;
      end else if (mask_we) begin
         mask_r <= mask_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(((sts_r & ~clr_w1c) | set_evt) & (mask_we ? mask_wdata : mask_r));
      end
   end
endmodule : tbd_int_regs

/* src/tbd_cmd_decoder.sv */
// Transmit buffer command decoder: strips padding, disables offset lanes, checks lengths
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "tbd_params.svh"

module tbd_cmd_decoder (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_valid,
   input wire logic [31:0] wr_data,
   output logic out_valid,
   output logic [31:0] out_data,
   output logic [3:0] out_be,
   output logic out_last,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq
);
   import tbd_pkg::*;

   // Byte lane mask of one DWORD at byte position pos
   function automatic logic [3:0] tbd_lane_mask(input logic [11:0] pos,
                                                input logic [4:0] off,
                                                input logic [10:0] size);
      logic [3:0] m;
      logic [12:0] p;
      logic [12:0] lo;
      logic [12:0] hi;
      m = 4'h0;
      lo = 13'(off);
      hi = 13'(off) + 13'(size);
      for (int l = 0; l < 4; l++) begin
         p = 13'(pos) + 13'(l);
         m[l] = (p >= lo) && (p < hi);
      end
      return m;
   endfunction : tbd_lane_mask

   tbd_cmd_if cif ();

   tbd_state_t state_r;
   tbd_cmd_a_t cmd_r;
   logic [9:0] data_dw_r;
   logic [9:0] total_dw_r;
   logic [9:0] dw_cnt_r;
   logic [11:0] pkt_sum_r;
   logic [11:0] pkt_sum_nxt;
   logic [10:0] pkt_len_r;
   logic [10:0] len_in;
   logic done_r;
   logic finish;
   logic len_mismatch;
   logic [`TBD_STS_W-1:0] set_evt;
   logic [`TBD_STS_W-1:0] clr_w1c;
   logic [`TBD_STS_W-1:0] sts_r;
   logic [`TBD_STS_W-1:0] mask_r;
   logic irq_r;

   assign cif.word = wr_data;

   tbd_cmd_decode u_dec (
      .cif(cif)
   );

   assign len_in = wr_data[`TBD_B_LEN_HI:`TBD_B_LEN_LO];
   assign pkt_sum_nxt = cmd_r.first ? 12'(cmd_r.size) : pkt_sum_r + 12'(cmd_r.size);

   // Buffer ends on its last DWORD, or right after the second word if empty
   always_comb begin
      finish = 1'b0;
      if (wr_valid) begin
         if (state_r == TBD_ST_CMD_B) begin
            finish = (total_dw_r == 10'h000);
         end else if (state_r == TBD_ST_DATA) begin
            finish = (dw_cnt_r == total_dw_r - 10'h001);
         end
      end
   end

   // Command word, command word, payload; no other order is decoded
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= TBD_ST_CMD_A;
      end else if (wr_valid) begin
         case (state_r)
            TBD_ST_CMD_A: state_r <= TBD_ST_CMD_B;
            TBD_ST_CMD_B: state_r <= finish ? TBD_ST_CMD_A : TBD_ST_DATA;
            TBD_ST_DATA: state_r <= finish ? TBD_ST_CMD_A : TBD_ST_DATA;
            default: state_r <= TBD_ST_CMD_A;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_r <= '0;
         data_dw_r <= 10'h000;
         total_dw_r <= 10'h000;
      end else if (wr_valid && state_r == TBD_ST_CMD_A) begin
         cmd_r <= cif.cmd;
         data_dw_r <= cif.data_dw;
         total_dw_r <= cif.total_dw;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dw_cnt_r <= 10'h000;
      end else if (wr_valid && state_r == TBD_ST_CMD_B) begin
         dw_cnt_r <= 10'h000;
      end else if (wr_valid && state_r == TBD_ST_DATA) begin
         dw_cnt_r <= dw_cnt_r + 10'h001;
      end
   end

   // Packet length is taken from the first segment; later segments must repeat it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pkt_sum_r <= 12'h000;
         pkt_len_r <= 11'h000;
      end else if (wr_valid && state_r == TBD_ST_CMD_B) begin
         pkt_sum_r <= pkt_sum_nxt;
         if (cmd_r.first) begin
            pkt_len_r <= len_in;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_r <= 1'b0;
      end else begin
         done_r <= finish;
      end
   end

   assign len_mismatch = pkt_sum_r != 12'(pkt_len_r);

   // Events; completion and packet length checked one cycle after the buffer completes, alignment and segment length on their own words
   always_comb begin
      set_evt = '0;
      set_evt[`TBD_STS_CMPL] = done_r && cmd_r.completion_interrupt_request;
      set_evt[`TBD_STS_ERR] = (wr_valid && state_r == TBD_ST_CMD_A && cif.bad_align)
         || (wr_valid && state_r == TBD_ST_CMD_B && !cmd_r.first && len_in != pkt_len_r)
         || (done_r && cmd_r.last && len_mismatch);
   end

   // Only DWORDs up to the last payload DWORD pass; lanes outside offset and size are disabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_data <= 32'h00000000;
         out_be <= 4'h0;
         out_last <= 1'b0;
      end else begin
         out_valid <= wr_valid && state_r == TBD_ST_DATA && dw_cnt_r < data_dw_r;
         out_data <= wr_data;
         out_be <= tbd_lane_mask({dw_cnt_r, 2'b00}, cmd_r.offset, cmd_r.size);
         out_last <= wr_valid && state_r == TBD_ST_DATA && cmd_r.last
            && dw_cnt_r == data_dw_r - 10'h001;
      end
   end

   // Register bus
   assign clr_w1c = (reg_wr && reg_addr == `TBD_OFF_INTERRUPT_STATUS_REGISTER) ? reg_wdata[`TBD_STS_W-1:0] : '0;

   tbd_int_regs u_int (
      .clk(clk),
      .rst(rst),
      .set_evt(set_evt),
      .clr_w1c(clr_w1c),
      .mask_we(reg_wr && reg_addr == `TBD_OFF_INT_MASK),
      .mask_wdata(reg_wdata[`TBD_STS_W-1:0]),
      .sts_r(sts_r),
      .mask_r(mask_r),
      .irq_r(irq_r)
   );

   assign irq = irq_r;

   // Read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `TBD_OFF_INTERRUPT_STATUS_REGISTER: reg_rdata <= 32'(sts_r);
            `TBD_OFF_INT_MASK: reg_rdata <= 32'(mask_r);
            `TBD_OFF_PKT_STAT: reg_rdata <= {5'h00, pkt_len_r, 4'h0, pkt_sum_r};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // Checks
   a_cmd_order: assert property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_CMD_A |=> state_r == TBD_ST_CMD_B)
      else $error("second command word not expected after first");

   a_ioc_flag_set: assert property (@(posedge clk) disable iff (rst)
      done_r && cmd_r.completion_interrupt_request |=> sts_r[`TBD_STS_CMPL])
      else $error("completion flag not set after buffer load");

   a_pad_dropped: assert property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_DATA && dw_cnt_r >= data_dw_r |=> !out_valid)
      else $error("padding DWORD reached output");

   a_offset_lane: assert property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_DATA && dw_cnt_r == 10'h000
      && cmd_r.offset == 5'h02 && cmd_r.size != 11'h000
      |=> (out_be == 4'hC || (cmd_r.size == 11'h001 && out_be == 4'h4)))
      else $error("first lane does not follow start offset");

   a_rsvd_align_err: assert property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_CMD_A && wr_data[25:24] == 2'h3
      |=> sts_r[`TBD_STS_ERR])
      else $error("reserved alignment code not flagged");

   a_align_round: assert property (@(posedge clk) disable iff (rst)
      state_r == TBD_ST_CMD_B && cmd_r.align == 2'h2 |-> total_dw_r[2:0] == 3'h0
      && total_dw_r >= data_dw_r && total_dw_r < data_dw_r + 10'h008)
      else $error("32-byte alignment count wrong");

   a_len_check: assert property (@(posedge clk) disable iff (rst)
      done_r && cmd_r.last && pkt_sum_r != 12'(pkt_len_r) |=> sts_r[`TBD_STS_ERR])
      else $error("packet length mismatch not flagged");

   a_first_sum: assert property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_CMD_B && cmd_r.first
      |=> pkt_sum_r == 12'($past(cmd_r.size)) && pkt_len_r == $past(len_in))
      else $error("first segment did not restart the packet sum");

   a_last_marker: assert property (@(posedge clk) disable iff (rst)
      out_last |-> out_valid && cmd_r.last)
      else $error("packet end marker outside last segment");

   // Level output tracks status and mask in the same cycle
   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      irq == |(sts_r & mask_r))
      else $error("interrupt level disagrees with status and mask");

   a_empty_buf_done: assert property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_CMD_B && total_dw_r == 10'h000 |=> state_r == TBD_ST_CMD_A)
      else $error("empty buffer did not complete after second word");

   a_align16_round: assert property (@(posedge clk) disable iff (rst)
      state_r == TBD_ST_CMD_B && cmd_r.align == 2'h1 |-> total_dw_r[1:0] == 2'h0
      && total_dw_r >= data_dw_r && total_dw_r < data_dw_r + 10'h004)
      else $error("16-byte alignment count wrong");

   a_seg_len_err: assert property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_CMD_B && !cmd_r.first && len_in != pkt_len_r
      |=> sts_r[`TBD_STS_ERR])
      else $error("segment packet length change not flagged");

   // Read data must not linger past its one cycle
   a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data stood outside its cycle");

   c_ioc_irq: cover property (@(posedge clk) disable iff (rst)
      done_r && cmd_r.completion_interrupt_request ##[1:2] irq);

   c_multi_seg: cover property (@(posedge clk) disable iff (rst)
      done_r && !cmd_r.last ##[1:100] done_r && cmd_r.last && !len_mismatch);

   c_pad_strip: cover property (@(posedge clk) disable iff (rst)
      wr_valid && state_r == TBD_ST_DATA && dw_cnt_r >= data_dw_r);

endmodule : tbd_cmd_decoder

/* verification/tbd_host_model.sv */
// Host model that writes transmit buffers into the data path
`timescale 1ns/1ps
module tbd_host_model (
   input wire logic clk,
   output logic wr_valid,
   output logic [31:0] wr_data
);
   initial begin
      wr_valid = 1'b0;
      wr_data = 32'h0;
   end

   // Valid is held across back-to-back words; a gapped word leaves inverted data behind it
   task automatic put(input logic [31:0] w, input int gap);
      wr_valid <= 1'b1;
      wr_data <= w;
      @(posedge clk);
      if (gap > 0) begin
         wr_valid <= 1'b0;
         wr_data <= ~w;
         repeat (gap) @(posedge clk);
      end
   endtask : put

   task automatic send_buf(input logic completion_interrupt_request, input logic [1:0] align, input logic [4:0] off,
         input logic [10:0] size, input logic first, input logic last, input logic [10:0] len,
         input int gap);
      int n;
      int m;
      logic [31:0] w;
      n = (off + size + 3) / 4;
      m = (align == 2'h1) ? 4 : (align == 2'h2) ? 8 : 1;
      w = 32'h0;
      w[31] = completion_interrupt_request;
      w[25:24] = align;
      w[20:16] = off;
      w[13] = first;
      w[12] = last;
      w[10:0] = size;
      put(w, gap);
      put({21'h0, len}, gap);
      for (int i = 0; i < ((n + m - 1) / m) * m; i++) begin
         put({16'hDA7A, 16'(i)}, gap);
      end
      wr_valid <= 1'b0;
      wr_data <= ~wr_data;
   endtask : send_buf
endmodule : tbd_host_model

/* verification/tb.sv */
// Self-checking bench for the transmit command decoder
`timescale 1ns/1ps
module tb;
   typedef struct {
      logic completion_interrupt_request; logic [1:0] align; logic [4:0] off; logic [10:0] size;
      logic first; logic last; logic [10:0] len; int gap; logic [1:0] sts;
   } tbd_row_t;

   logic clk, rst, wr_valid, out_valid, out_last, reg_wr, reg_rd, irq;
   logic [31:0] wr_data, out_data, reg_wdata, reg_rdata;
   logic [3:0] out_be, be_exp;
   logic [7:0] reg_addr;
   int errors = 0;
   int total_checks = 0;
   int cur_off, cur_size, beats, idx;
   logic cur_last;
   tbd_row_t rows[10] = '{
      '{1, 2'h0, 2, 3, 1, 1, 3, 0, 2'h1}, '{0, 2'h1, 0, 4, 1, 1, 4, 0, 2'h0},
      '{1, 2'h2, 31, 5, 1, 1, 5, 1, 2'h1}, '{0, 2'h1, 5, 11, 1, 1, 11, 0, 2'h0},
      '{0, 2'h0, 1, 6, 1, 0, 14, 0, 2'h0}, '{0, 2'h0, 3, 4, 0, 0, 14, 0, 2'h0},
      '{1, 2'h2, 0, 4, 0, 1, 14, 0, 2'h1}, '{0, 2'h0, 0, 8, 1, 1, 7, 0, 2'h2},
      '{0, 2'h3, 0, 4, 1, 1, 4, 0, 2'h2}, '{1, 2'h0, 0, 0, 1, 1, 0, 0, 2'h1}};

   tbd_host_model host (.clk(clk), .wr_valid(wr_valid), .wr_data(wr_data));
   tbd_cmd_decoder dut (.clk(clk), .rst(rst), .wr_valid(wr_valid), .wr_data(wr_data),
      .out_valid(out_valid), .out_data(out_data), .out_be(out_be), .out_last(out_last),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   function automatic logic [3:0] exp_be(input int i);
      logic [3:0] be;
      for (int k = 0; k < 4; k++) begin
         be[k] = (4 * i + k >= cur_off) && (4 * i + k < cur_off + cur_size);
      end
      return be;
   endfunction : exp_be

   function automatic int count_beats();
      int c;
      c = 0;
      for (int i = 0; i < (cur_off + cur_size + 3) / 4; i++) begin
         if (exp_be(i) != 4'h0) c++;
      end
      return c;
   endfunction : count_beats

   // Beat index rides in the low half of each payload word
   always @(posedge clk) begin
      if (!rst && out_valid) begin
         idx = out_data[15:0];
         be_exp = exp_be(idx);
         check_word("out_be", {28'h0, be_exp}, {28'h0, out_be});
         check_word("out_data", 32'hDA7A, {16'h0, out_data[31:16]});
         check_word("beat before padding", 32'h1,
            32'(idx < (cur_off + cur_size + 3) / 4));
         check_word("out_last", {31'h0, cur_last && be_exp != 4'h0 &&
            idx == (cur_off + cur_size - 1) / 4}, {31'h0, out_last});
         if (be_exp != 4'h0) beats++;
      end
   end

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check_word("reg_rdata", exp, reg_rdata);
      @(posedge clk);
   endtask : reg_read

   task automatic run_row(input tbd_row_t r);
      cur_off = r.off;
      cur_size = r.size;
      cur_last = r.last;
      beats = 0;
      host.send_buf(r.completion_interrupt_request, r.align, r.off, r.size, r.first, r.last, r.len, r.gap);
      repeat (4) @(posedge clk);
      check_word("beats", 32'(count_beats()), 32'(beats));
      reg_read(8'h00, {30'h0, r.sts});
   endtask : run_row

   task automatic complete_run;
      if (errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   initial begin
      #(40 * 6000);
      errors++;
      complete_run();
   end

   initial begin
      rst = 1'b1;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_read(8'h00, 32'h0);
      reg_read(8'h04, 32'h0);
      reg_write(8'h04, 32'h3);
      foreach (rows[i]) begin
         run_row(rows[i]);
         check_word("irq", {31'h0, |rows[i].sts}, {31'h0, irq});
         if (i == 7) reg_read(8'h08, {5'h0, 11'd7, 4'h0, 12'd8});
         reg_write(8'h00, 32'h3);
         check_word("irq after clear", 32'h0, {31'h0, irq});
      end
      // Masked completion must stay silent until the mask opens
      reg_write(8'h04, 32'h0);
      run_row(rows[0]);
      check_word("irq masked", 32'h0, {31'h0, irq});
      reg_write(8'h04, 32'h1);
      check_word("irq unmasked", 32'h1, {31'h0, irq});
      reg_write(8'h0C, 32'h3);
      reg_read(8'h0C, 32'h0);
      reg_read(8'h04, 32'h1);
      reg_write(8'h00, 32'h1);
      reg_read(8'h00, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_read(8'h04, 32'h0);
      check_word("irq after reset", 32'h0, {31'h0, irq});
      run_row(rows[3]);
      complete_run();
   end
endmodule : tb
